// ===== verilog/dci_top.sv
// dci_top: register file and output control for the on-chip 12-bit voltage converter.
// assumes a byte-wide core register bus: one-cycle write and read strobes,
// whole-byte access only, read data returned from a flop one cycle after the strobe.
`timescale 1ns/1ps

// Function
// - 12-bit output changes on low write, clear or width-mode change
// - code right-justified: low byte, high nibble
// - control bit 4 selects output pin
// - bit 3: low byte to MSBs, LSBs zero
// - control bit 2 selects output range
// - bit 1 low holds data registers zero
// - bit 0 enables, zero powers converter down
// - data registers reset zero, byte access only
// - control bits 7 to 5 reserved
module dci_top (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	input  wire logic [7:0]  i_sfr_addr,
	input  wire logic [7:0]  i_sfr_wdata,
	input  wire logic        i_sfr_wr,
	input  wire logic        i_sfr_rd,
	output logic      [7:0]  o_sfr_rdata,
	output logic             o_sfr_hit,
	output logic      [11:0] o_dac_code,
	output logic             o_output_range_select,
	output logic             o_output_pin_select,
	output logic             o_power_down,
	output logic             o_code_updated
);

	// bus request gathered into one carrier
	dci_pkg::dci_sfr_req_t req;

	assign req = '{addr: i_sfr_addr, wdata: i_sfr_wdata, wr: i_sfr_wr, rd: i_sfr_rd};

	// address decode
	wire sel_low  = (req.addr == dci_pkg::DCI_ADDR_CODE_LOW);
	wire sel_high = (req.addr == dci_pkg::DCI_ADDR_CODE_HIGH);
	wire sel_ctrl = (req.addr == dci_pkg::DCI_ADDR_CONTROL);
	wire sel_any  = sel_low | sel_high | sel_ctrl;

	// write strobes, whole bytes only
	wire wr_low  = req.wr & sel_low;
	wire wr_high = req.wr & sel_high;
	wire wr_ctrl = req.wr & sel_ctrl;

	// register contents
	logic [7:0] code_low;
	logic [7:0] code_high;
	logic [7:0] control;

	dci_pkg::dci_ctrl_t ctrl_now;
	dci_pkg::dci_ctrl_t ctrl_next;

	// control register; reserved bits masked off
	dci_byte_reg #(
		.WIDTH     (8),
		.RESET_VAL (dci_pkg::DCI_RST_CONTROL),
		.WR_MASK   (dci_pkg::DCI_CONTROL_MASK)
	) u_control (
		.i_ref_clk   (i_ref_clk),
		.i_rst_n     (i_rst_n),
		.i_hold_zero (1'b0),
		.i_wr        (wr_ctrl),
		.i_wdata     (req.wdata),
		.o_value     (control)
	);

	// control fields as stored and as they will be after this edge
	wire [7:0] control_next = wr_ctrl ? (req.wdata & dci_pkg::DCI_CONTROL_MASK) : control;

	assign ctrl_now = '{
		pin_select:   control[dci_pkg::DCI_BIT_PIN_SELECT],
		byte_mode:    control[dci_pkg::DCI_BIT_BYTE_MODE],
		range_select: control[dci_pkg::DCI_BIT_RANGE_SELECT],
		code_clear_n: control[dci_pkg::DCI_BIT_CODE_CLEAR_N],
		power_enable: control[dci_pkg::DCI_BIT_POWER_ENABLE]
	};

	assign ctrl_next = '{
		pin_select:   control_next[dci_pkg::DCI_BIT_PIN_SELECT],
		byte_mode:    control_next[dci_pkg::DCI_BIT_BYTE_MODE],
		range_select: control_next[dci_pkg::DCI_BIT_RANGE_SELECT],
		code_clear_n: control_next[dci_pkg::DCI_BIT_CODE_CLEAR_N],
		power_enable: control_next[dci_pkg::DCI_BIT_POWER_ENABLE]
	};

	// data registers are held at zero while the clear bit is low
	wire hold_data = ~ctrl_now.code_clear_n;

	// low data byte, zero at power-on
	dci_byte_reg #(
		.WIDTH     (8),
		.RESET_VAL (dci_pkg::DCI_RST_CODE_LOW)
	) u_code_low (
		.i_ref_clk   (i_ref_clk),
		.i_rst_n     (i_rst_n),
		.i_hold_zero (hold_data),
		.i_wr        (wr_low),
		.i_wdata     (req.wdata),
		.o_value     (code_low)
	);

	// high data byte, zero at power-on
	dci_byte_reg #(
		.WIDTH     (8),
		.RESET_VAL (dci_pkg::DCI_RST_CODE_HIGH)
	) u_code_high (
		.i_ref_clk   (i_ref_clk),
		.i_rst_n     (i_rst_n),
		.i_hold_zero (hold_data),
		.i_wr        (wr_high),
		.i_wdata     (req.wdata),
		.o_value     (code_high)
	);

	// data register values after this edge, clear taken into account
	wire [7:0] low_next  = hold_data ? 8'h00 : (wr_low ? req.wdata : code_low);
	wire [7:0] high_next = hold_data ? 8'h00 : (wr_high ? req.wdata : code_high);

	// effective code: right-justified 12-bit or low byte on the top 8 bits
	wire [11:0] code_wide = {high_next[dci_pkg::DCI_NIBBLE_WIDTH-1:0], low_next};
	wire [11:0] code_byte = {low_next, dci_pkg::DCI_PAD_ZERO};
	wire [11:0] code_sel  = ctrl_next.byte_mode ? code_byte : code_wide;

	// loads: a low-byte write, a clear, or a change of width mode; a high write alone waits
	wire mode_change = wr_ctrl & (ctrl_next.byte_mode != ctrl_now.byte_mode);
	wire load_code   = wr_low | hold_data | mode_change;

	// registered outputs toward the converter
	dci_pkg::dci_analog_t analog;
	logic                 updated;

	dci_code_stage u_code_stage (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_load    (load_code),
		.i_code    (code_sel),
		.i_ctrl    (ctrl_next), // static controls land on the edge of the control write
		.o_analog  (analog),
		.o_updated (updated)
	);

	assign o_dac_code            = analog.code;
	assign o_output_range_select = analog.range_select;
	assign o_output_pin_select   = analog.pin_select;
	assign o_power_down          = analog.power_down;
	assign o_code_updated        = updated;

	// read selection; reserved control bits read as zero
	wire [7:0] rd_value = sel_low  ? code_low :
	                      sel_high ? code_high :
	                      sel_ctrl ? (control & dci_pkg::DCI_CONTROL_MASK) :
	                      dci_pkg::DCI_UNMAPPED_RDATA;

	logic [7:0] rdata_q;
	logic       hit_q;

	// read data and hit flag, captured on the read strobe and held until the next
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q <= dci_pkg::DCI_UNMAPPED_RDATA;
			hit_q   <= 1'b0;
		end else if (req.rd) begin
			rdata_q <= rd_value;
			hit_q   <= sel_any;
		end
	end

	assign o_sfr_rdata = rdata_q;
	assign o_sfr_hit   = hit_q;

endmodule : dci_top

// ===== verilog/dci_pkg.sv
// dci_pkg: constants and carrier types for the converter control block.
// assumes a byte-wide register bus from the processor core and a 12-bit converter stage.
package dci_pkg;

	// register offsets on the core register bus
	localparam logic [7:0] DCI_ADDR_CODE_LOW  = 8'hfb;
	localparam logic [7:0] DCI_ADDR_CODE_HIGH = 8'hfc;
	localparam logic [7:0] DCI_ADDR_CONTROL   = 8'hfd;

	// reset values
	localparam logic [7:0] DCI_RST_CODE_LOW  = 8'h00;
	localparam logic [7:0] DCI_RST_CODE_HIGH = 8'h00;
	localparam logic [7:0] DCI_RST_CONTROL   = 8'h00;

	// value read back from an unmapped address
	localparam logic [7:0] DCI_UNMAPPED_RDATA = 8'h00;

	// control register field positions
	localparam int DCI_BIT_POWER_ENABLE = 0;
	localparam int DCI_BIT_CODE_CLEAR_N = 1;
	localparam int DCI_BIT_RANGE_SELECT = 2;
	localparam int DCI_BIT_BYTE_MODE    = 3;
	localparam int DCI_BIT_PIN_SELECT   = 4;

	// implemented control bits, reserved bits 7..5 read as zero
	localparam logic [7:0] DCI_CONTROL_MASK = 8'h1f;

	// code layout
	localparam int DCI_CODE_WIDTH = 12;
	localparam int DCI_BYTE_WIDTH = 8;
	localparam int DCI_NIBBLE_WIDTH = DCI_CODE_WIDTH - DCI_BYTE_WIDTH;
	localparam logic [DCI_NIBBLE_WIDTH-1:0] DCI_PAD_ZERO = 4'h0;
	localparam logic [DCI_CODE_WIDTH-1:0]   DCI_CODE_ZERO = 12'h000;

	// one register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} dci_sfr_req_t;

	// decoded control register
	typedef struct packed {
		logic pin_select;
		logic byte_mode;
		logic range_select;
		logic code_clear_n;
		logic power_enable;
	} dci_ctrl_t;

	// signals to the analog converter stage
	typedef struct packed {
		logic [DCI_CODE_WIDTH-1:0] code;
		logic                      range_select;
		logic                      pin_select;
		logic                      power_down;
	} dci_analog_t;

endpackage : dci_pkg

// ===== verilog/dci_byte_reg.sv
// dci_byte_reg: one byte-wide software register with write strobe and hold-at-zero.
// assumes the write strobe and data are synchronous to i_ref_clk.
`timescale 1ns/1ps
module dci_byte_reg #(
	parameter int                 WIDTH     = 8,
	parameter logic [WIDTH-1:0]   RESET_VAL = '0,
	parameter logic [WIDTH-1:0]   WR_MASK   = '1
) (
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_hold_zero,
	input  wire logic             i_wr,
	input  wire logic [WIDTH-1:0] i_wdata,
	output logic      [WIDTH-1:0] o_value
);

	logic [WIDTH-1:0] value_q;
	logic [WIDTH-1:0] value_d;

	// elaboration check: the register is at most one byte wide
	if (WIDTH < 1 || WIDTH > 8) begin : g_width_check
		$error("dci_byte_reg: WIDTH must be 1 to 8");
	end

	// hold-at-zero wins over a write; masked bits never store
	assign value_d = i_hold_zero ? '0 : (i_wr ? (i_wdata & WR_MASK) : value_q);

	// storage
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			value_q <= RESET_VAL;
		end else begin
			value_q <= value_d;
		end
	end

	assign o_value = value_q;

endmodule : dci_byte_reg

// ===== verilog/dci_code_stage.sv
// dci_code_stage: registered outputs toward the analog converter stage.
// assumes load and clear are single-cycle decisions made by the register logic.
`timescale 1ns/1ps
module dci_code_stage (
	input  wire logic                               i_ref_clk,
	input  wire logic                               i_rst_n,
	input  wire logic                               i_load,
	input  wire logic [dci_pkg::DCI_CODE_WIDTH-1:0] i_code,
	input  wire dci_pkg::dci_ctrl_t                 i_ctrl,
	output dci_pkg::dci_analog_t                    o_analog,
	output logic                                    o_updated
);

	dci_pkg::dci_analog_t analog_q;
	dci_pkg::dci_analog_t analog_d;
	logic                 updated_q;

	// code moves only on a load; static controls follow the control register
	always_comb begin
		analog_d              = analog_q;
		analog_d.code         = i_load ? i_code : analog_q.code;
		analog_d.range_select = i_ctrl.range_select;
		analog_d.pin_select   = i_ctrl.pin_select;
		analog_d.power_down   = ~i_ctrl.power_enable;
	end

	// output flops; power-down asserted out of reset
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			analog_q  <= '{code: dci_pkg::DCI_CODE_ZERO, range_select: 1'b0,
			               pin_select: 1'b0, power_down: 1'b1};
			updated_q <= 1'b0;
		end else begin
			analog_q  <= analog_d;
			updated_q <= i_load && (i_code != analog_q.code);
		end
	end

	assign o_analog  = analog_q;
	assign o_updated = updated_q;

endmodule : dci_code_stage

// ===== verif/dci_top_checker.sv
// dci_top_checker: concurrent checks on the ports of dci_top.
// assumes one core clock and an async active-low reset.
`timescale 1ns/1ps
module dci_top_checker (
	input wire logic        i_ref_clk,
	input wire logic        i_rst_n,
	input wire logic [7:0]  i_sfr_addr,
	input wire logic [7:0]  i_sfr_wdata,
	input wire logic        i_sfr_wr,
	input wire logic        i_sfr_rd,
	input wire logic [7:0]  o_sfr_rdata,
	input wire logic        o_sfr_hit,
	input wire logic [11:0] o_dac_code,
	input wire logic        o_output_range_select,
	input wire logic        o_output_pin_select,
	input wire logic        o_power_down,
	input wire logic        o_code_updated
);
	// a control write that clears the data registers; its zero load lands one edge later
	logic clr_wr_q;
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			clr_wr_q <= 1'b0;
		end else begin
			clr_wr_q <= i_sfr_wr && i_sfr_addr == 8'hfd && !i_sfr_wdata[1];
		end
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// bus request shapes
	sequence ctrl_wr; i_sfr_wr && i_sfr_addr == 8'hfd; endsequence
	sequence hi_wr; i_sfr_wr && i_sfr_addr == 8'hfc && !i_sfr_rd && !clr_wr_q; endsequence
	sequence ctrl_rd; i_sfr_rd && i_sfr_addr == 8'hfd; endsequence
	sequence miss_rd; i_sfr_rd && i_sfr_addr < 8'hfb; endsequence
	a_pin_follows: assert property (ctrl_wr |=> o_output_pin_select == $past(i_sfr_wdata[4]))
		else $error("pin select does not follow control bit 4");
	a_range_follows: assert property (ctrl_wr |=>
		o_output_range_select == $past(i_sfr_wdata[2]))
		else $error("range select does not follow control bit 2");
	a_power_down_follows: assert property (ctrl_wr |=>
		o_power_down == !$past(i_sfr_wdata[0]))
		else $error("power down does not follow control bit 0");
	a_high_no_update: assert property (hi_wr |=> $stable(o_dac_code))
		else $error("high byte write moved the code");
	a_update_pulse: assert property ($changed(o_dac_code) |-> o_code_updated)
		else $error("code changed without update pulse");
	a_reserved_zero: assert property (ctrl_rd |=> o_sfr_hit && o_sfr_rdata[7:5] == 3'h0)
		else $error("reserved control bits read nonzero");
	a_miss_read: assert property (miss_rd |=> !o_sfr_hit && o_sfr_rdata == 8'h00)
		else $error("unmapped read not refused");
	a_rdata_holds: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata) && $stable(o_sfr_hit))
		else $error("read data moved without a read");
endmodule : dci_top_checker

// ===== verif/dci_top_tb.sv
// dci_top_tb: register-level tests of the converter control block.
// assumes dci_top and its checker are compiled first.
`timescale 1ns/1ps
module dci_top_tb;
	logic       i_ref_clk, i_rst_n, i_sfr_wr, i_sfr_rd, o_sfr_hit;
	logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata;
	logic [11:0] o_dac_code;
	logic       o_output_range_select, o_output_pin_select, o_power_down, o_code_updated;
	int         error_cnt = 0;
	int         checks = 0;
	dci_top dci_top_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_sfr_addr(i_sfr_addr),
		.i_sfr_wdata(i_sfr_wdata), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
		.o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit), .o_dac_code(o_dac_code),
		.o_output_range_select(o_output_range_select),
		.o_output_pin_select(o_output_pin_select), .o_power_down(o_power_down),
		.o_code_updated(o_code_updated));
	// 200 MHz core clock
	initial begin
		i_ref_clk = 1'b0;
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end
	// compare one value and count it
	task automatic cmp(input logic [12:0] got, input logic [12:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// one-cycle write strobe after an idle edge, so strobes never toggle twice in a step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_ref_clk) #1;
		i_sfr_addr = a;
		i_sfr_wdata = d;
		i_sfr_wr = 1'b1;
		@(posedge i_ref_clk) #1;
		i_sfr_wr = 1'b0;
	endtask : wr
	// one-cycle read strobe, data checked one cycle later
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
		@(posedge i_ref_clk) #1;
		i_sfr_addr = a;
		i_sfr_rd = 1'b1;
		@(posedge i_ref_clk) #1;
		i_sfr_rd = 1'b0;
		cmp({4'h0, o_sfr_hit, o_sfr_rdata}, {4'h0, hit, exp});
	endtask : rd
	// verdict and end of run
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	// watchdog
	initial begin
		#20000;
		error_cnt++;
		end_of_test();
	end
	// main sequence
	initial begin
		{i_rst_n, i_sfr_wr, i_sfr_rd, i_sfr_addr, i_sfr_wdata} = '0;
		repeat (5) @(posedge i_ref_clk);
		#1 i_rst_n = 1'b1;
		cmp(o_power_down, 1'b1);
		rd(8'hfb, 8'h00, 1'b1);
		rd(8'hfc, 8'h00, 1'b1);
		rd(8'hfd, 8'h00, 1'b1);
		// the clear bit resets low, so data writes need it set first
		wr(8'hfd, 8'h03);
		cmp(o_power_down, 1'b0);
		wr(8'hfc, 8'h5a);
		cmp(o_dac_code, 12'h000);
		rd(8'hfc, 8'h5a, 1'b1);
		wr(8'hfb, 8'hbc);
		cmp({o_code_updated, o_dac_code}, 13'h1abc);
		wr(8'hfd, 8'hff);
		cmp(o_dac_code, 12'hbc0);
		cmp({o_output_pin_select, o_output_range_select, o_power_down}, 3'h6);
		rd(8'hfd, 8'h1f, 1'b1);
		wr(8'hfd, 8'h02);
		cmp(o_dac_code, 12'habc);
		cmp({o_output_pin_select, o_output_range_select, o_power_down}, 3'h1);
		wr(8'hfd, 8'h00);
		@(posedge i_ref_clk) #1;
		cmp(o_dac_code, 12'h000);
		rd(8'hfb, 8'h00, 1'b1);
		rd(8'hfc, 8'h00, 1'b1);
		wr(8'hfb, 8'h33);
		cmp(o_dac_code, 12'h000);
		wr(8'hfd, 8'h03);
		wr(8'hfb, 8'h33);
		cmp(o_dac_code, 12'h033);
		rd(8'h10, 8'h00, 1'b0);
		end_of_test();
	end
endmodule : dci_top_tb
bind dci_top dci_top_checker dci_top_checker_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
	.i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_wr(i_sfr_wr),
	.i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit),
	.o_dac_code(o_dac_code), .o_output_range_select(o_output_range_select),
	.o_output_pin_select(o_output_pin_select), .o_power_down(o_power_down),
	.o_code_updated(o_code_updated));
